// file: dac_cal_defs.svh
`ifndef DAC_CAL_DEFS_SVH
`define DAC_CAL_DEFS_SVH

// Field widths and layout of the code path
`define CODE_W        16
`define NARROW_DROP   2
`define GAIN_UNITY    16'h8000
`define CODE_MAX_WIDE 16'hFFFF
`define CODE_RESET    16'h0000
`define GAIN_RESET    16'h8000
`define OFFSET_RESET  16'h0000
`define CODE_MIN        16'h0000
`define CODE_MAX_NARROW 16'hFFFC
`define WIDE_MASK       16'hFFFF
`define NARROW_MASK     16'hFFFC
`define GAIN_HALF       17'h0_8000

// Span select encodings
`define SPAN_FULL     1'b0
`define SPAN_NARROW   1'b1

`endif

// file: dac_cal_monitor.sv
`timescale 1ns/1ps
module dac_cal_monitor
  import dac_cal_pkg::*;
(
  input wire logic                       clk,
  input wire logic                       reset,
  input wire logic                       clkEn,
  input wire logic                       codeWrite,
  input wire logic                       clearState,
  input wire logic                       logicSupplyOk,
  input wire logic                       output_supplyOk,
  input wire dac_cal_pkg::alarm_action_t alarm_action_config,
  input wire logic                       spanSelect,
  input wire logic                       clear_span_select,
  input wire logic [15:0]                dacCode,
  input wire dac_cal_pkg::span_t         span,
  input wire logic                       alarm
);
  // One clock domain with a synchronous reset
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire ok  = logicSupplyOk && output_supplyOk;
  wire bad = clkEn && !ok;
  wire run = clkEn && ok && !alarm;
  // Three calm cycles let the two-stage code path settle first
  sequence s_calm; (run && !codeWrite && !clearState) [*3]; endsequence
  property p_alm; clkEn |=> alarm == $past(!ok); endproperty
  a_alm: assert property (p_alm) else $error("alarm flag");
  property p_low; bad && alarm_action_config == ALARM_LOW_E |=> dacCode == 16'h0000; endproperty
  a_low: assert property (p_low) else $error("alarm low code");
  property p_high; bad && alarm_action_config == ALARM_HIGH_E |=> dacCode >= 16'hFFFC; endproperty
  a_high: assert property (p_high) else $error("alarm high code");
  property p_hold;
    (alarm && alarm_action_config == ALARM_HOLD_E) [*2] |-> $stable(dacCode);
  endproperty
  a_hold: assert property (p_hold) else $error("alarm hold code");
  property p_clr;
    bad && alarm_action_config == ALARM_CLEAR_E |=> span == $past(clear_span_select);
  endproperty
  a_clr: assert property (p_clr) else $error("alarm clear span");
  property p_span; run && !clearState |=> span == $past(spanSelect); endproperty
  a_span: assert property (p_span) else $error("normal span");
  property p_cspan; run && clearState |=> span == $past(clear_span_select); endproperty
  a_cspan: assert property (p_cspan) else $error("clear span");
  // Trim writes alone must leave the output alone
  property p_calm; s_calm |=> $stable(dacCode); endproperty
  a_calm: assert property (p_calm) else $error("code moved");
endmodule
////////////////////////////////////////
bind dac_code_calibration dac_cal_monitor mon (.*);

// file: dac_cal_pkg.sv
package dac_cal_pkg;

  // Output span chosen for the resistor string
  typedef enum logic
  {
    SPAN_FULL_E   = 1'b0,
    SPAN_NARROW_E = 1'b1
  } span_t;

  // Resolution variant
  typedef enum logic
  {
    RES_WIDE_E   = 1'b0,
    RES_NARROW_E = 1'b1
  } resolution_t;

  // Alarm action applied while a supply is out of window
  typedef enum logic [1:0]
  {
    ALARM_HOLD_E  = 2'b00,
    ALARM_LOW_E   = 2'b01,
    ALARM_HIGH_E  = 2'b11,
    ALARM_CLEAR_E = 2'b10
  } alarm_action_t;

endpackage

// file: dac_code_calibration.sv
`timescale 1ns/1ps
`include "dac_cal_defs.svh"
module dac_code_calibration
  import dac_cal_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       clkEn,
  input  wire dac_cal_pkg::resolution_t   resolution,
  input  wire logic                       codeWrite,
  input  wire logic [15:0]                codeData,
  input  wire logic                       gainWrite,
  input  wire logic [15:0]                gainData,
  input  wire logic                       offsetWrite,
  input  wire logic [15:0]                offsetData,
  input  wire logic                       spanSelect,
  input  wire logic                       clear_span_select,
  input  wire logic                       clearState,
  input  wire logic [15:0]                clearCode,
  input  wire logic                       logicSupplyOk,
  input  wire logic                       output_supplyOk,
  input  wire dac_cal_pkg::alarm_action_t alarm_action_config,
  output logic [15:0]                     dacCode,
  output dac_cal_pkg::span_t              span,
  output logic                            alarm,
  output logic [15:0]                     gainTrim,
  output logic [15:0]                     offsetTrim,
  output logic [15:0]                     writtenCode
);
  import dac_cal_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Clears the bits below the active resolution; used on all three fields.
  // Fields stay left-justified, so the narrow variant masks rather than shifts
  function automatic logic [15:0] alignField(input logic [15:0] f, input resolution_t r);
    logic [15:0] m;
    m = (r == RES_NARROW_E) ? `NARROW_MASK : `WIDE_MASK;
    alignField = f & m;
  endfunction

  // Largest code for the active resolution, still left-justified; the narrow
  // variant tops out with its two ignored bits at zero
  function automatic logic [15:0] maxCode(input resolution_t r);
    maxCode = (r == RES_NARROW_E) ? `CODE_MAX_NARROW : `CODE_MAX_WIDE;
  endfunction

  // Gain numerator in units of 2^-16: one half is 0x8000, so the numerator
  // is the field plus 0x8000 and never needs more than 17 bits
  function automatic logic [16:0] gainNumerator(input logic [15:0] g);
    gainNumerator = {1'b0, g} + `GAIN_HALF;
  endfunction

  // Offset field widened to 20 bits; its top bit carries negative weight
  function automatic logic signed [19:0] offsetValue(input logic [15:0] o);
    offsetValue = signed'({{4{o[15]}}, o});
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Field alignment

  // Every field is left-justified. On the narrow variant the two lowest bits
  // of the code, the gain and the offset are forced to zero here; the gain
  // product can set them again, so the clamped sum is masked once more.
  // The trims are aligned on use, not on write, so a later change of
  // resolution still picks the right bits of a stored trim.

  logic [15:0]        aData;
  logic [15:0]        aGain;
  logic [15:0]        aOffset;

  // Alignment of the written code and both stored trims
  always_comb
  begin
    aData   = alignField(codeData, resolution);
    aGain   = alignField(gain_reg, resolution);
    aOffset = alignField(offset_reg, resolution);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gain stage

  // The factor is (2^15 + field) / 2^16. The code is multiplied by the
  // 17-bit numerator and the 16 fraction bits are dropped. Dropping rather
  // than rounding is deliberate: a result may sit one step below the
  // rounded value, which software must accept.
  // The product never exceeds 33 bits, so no carry is lost.

  logic [16:0]        gainNum;
  logic [32:0]        product;
  logic [16:0]        scaled;

  // Multiply and truncate
  always_comb
  begin
    gainNum = gainNumerator(aGain);
    product = 33'(aData) * 33'(gainNum);
    scaled  = product[32:16];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offset stage and saturation

  // The scaled code is at most 17 bits and the offset is a signed 16-bit
  // value, so a 20-bit signed sum can neither wrap nor lose its sign.
  // A sum below zero or above the largest code is clamped to that end of
  // the range; the converter must never see a code that wraps around.
  // The upper end follows the resolution, so narrow mode clamps lower.

  logic signed [19:0] offsetS;
  logic signed [19:0] sumS;
  logic signed [19:0] maxS;
  logic               underRange;
  logic               overRange;
  logic [15:0]        clampCode;

  // Signed sum, range checks and the clamped result
  always_comb
  begin
    offsetS    = offsetValue(aOffset);
    sumS       = signed'({3'b000, scaled}) + offsetS;
    maxS       = signed'({4'h0, maxCode(resolution)});
    underRange = (sumS < 20'sh0_0000);
    overRange  = (sumS > maxS);
    if (underRange)
    begin
      clampCode = `CODE_MIN;
    end
    else if (overRange)
    begin
      clampCode = maxCode(resolution);
    end
    else
    begin
      clampCode = alignField(sumS[15:0], resolution);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trim storage

  // The trims are stored as written, with all sixteen bits, and read back
  // unchanged. Writing a trim never touches the converter code: the new
  // value is used only when the next code write passes through the path.

  logic [15:0]        gain_reg;
  logic [15:0]        gain_next;
  logic [15:0]        offset_reg;
  logic [15:0]        offset_next;

  // Next trim values
  always_comb
  begin
    gain_next   = gain_reg;
    offset_next = offset_reg;
    if (gainWrite)
    begin
      gain_next = gainData;
    end
    if (offsetWrite)
    begin
      offset_next = offsetData;
    end
  end

  // Trim registers; reset puts unity gain and zero offset in place
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      gain_reg   <= `GAIN_RESET;
      offset_reg <= `OFFSET_RESET;
    end
    else if (clkEn)
    begin
      gain_reg   <= gain_next;
      offset_reg <= offset_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Written code and calibrated code

  // A code write stores the aligned code and, in the same edge, the result
  // of the path computed with the trims held at that moment. A trim written
  // in the same cycle as the code is therefore not yet seen; software has
  // to write the trim first and the code afterwards.

  logic [15:0]        data_reg;
  logic [15:0]        data_next;
  logic [15:0]        cal_reg;
  logic [15:0]        cal_next;

  // Next code values; only a code write moves them
  always_comb
  begin
    data_next = data_reg;
    cal_next  = cal_reg;
    if (codeWrite)
    begin
      data_next = aData;
      cal_next  = clampCode;
    end
  end

  // Code registers; the calibrated code is one stage ahead of the output,
  // which keeps the multiplier out of the output selection path
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      data_reg <= `CODE_RESET;
      cal_reg  <= `CODE_RESET;
    end
    else if (clkEn)
    begin
      data_reg <= data_next;
      cal_reg  <= cal_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output selection: alarm, clear state, span

  // A supply outside its window raises the alarm in the next cycle, for as
  // long as the fault lasts. The alarm action then decides the code: hold
  // the last one, go to either end, or enter the clear state. The clear
  // state, entered by the pin or by the alarm, swaps the span for its
  // clear-state value, and the code too unless a hold, low or high alarm action sets it.
  // Limitation: supply faults are not filtered, so a one-cycle dip alarms.

  logic [15:0]        code_reg;
  logic [15:0]        code_next;
  logic               span_reg;
  logic               span_next;
  logic               alarm_reg;
  logic               alarm_next;
  logic               clearEff;

  // Next output values
  always_comb
  begin
    alarm_next = ~(logicSupplyOk & output_supplyOk);
    clearEff   = clearState | (alarm_next & (alarm_action_config == ALARM_CLEAR_E));
    // Span follows the clear span bit only while in clear state
    span_next  = clearEff ? clear_span_select : spanSelect;
    code_next  = clearEff ? alignField(clearCode, resolution) : cal_reg;
    // The alarm action overrides the normal code while the fault lasts;
    // hold keeps the register, so the last good code stays on the pin
    if (alarm_next)
    begin
      unique case (alarm_action_config)
        ALARM_HOLD_E:  code_next = code_reg;
        ALARM_LOW_E:   code_next = `CODE_MIN;
        ALARM_HIGH_E:  code_next = maxCode(resolution);
        ALARM_CLEAR_E: code_next = alignField(clearCode, resolution);
      endcase
    end
  end

  // Output registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      code_reg  <= `CODE_RESET;
      span_reg  <= `SPAN_FULL;
      alarm_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      code_reg  <= code_next;
      span_reg  <= span_next;
      alarm_reg <= alarm_next;
    end
  end

  // Outputs come straight from flip-flops; the stored trims are shown as written
  // and the code as aligned, so software can read them back
  assign dacCode     = code_reg;
  assign span        = span_t'(span_reg);
  assign alarm       = alarm_reg;
  assign gainTrim    = gain_reg;
  assign offsetTrim  = offset_reg;
  assign writtenCode = data_reg;

endmodule

// file: tb_dac_code_calibration.sv
`timescale 1ns/1ps
module tb_dac_code_calibration;
  import dac_cal_pkg::*;
  typedef struct {logic n; logic [15:0] d, g, o, e;} row_t;
  logic          clk, reset, clkEn, codeWrite, gainWrite, offsetWrite, spanSelect;
  logic          clear_span_select, clearState, logicSupplyOk, output_supplyOk, alarm;
  logic [15:0]   codeData, gainData, offsetData, clearCode, dacCode, gainTrim;
  logic [15:0]   offsetTrim, writtenCode;
  resolution_t   resolution;
  alarm_action_t alarm_action_config;
  span_t         span;
  int            error_cnt = 0;
  int            samples_checked = 0;
  logic [15:0]   alm [4] = '{16'h800F, 16'h0000, 16'h1234, 16'hFFFF};
  // Resolution, code, gain, offset and the corrected code they give
  row_t          rows [5] = '{
    '{1'h0, 16'h8000, 16'h8000, 16'hFFFF, 16'h7FFF},
    '{1'h1, 16'h1003, 16'h8003, 16'h0007, 16'h1004},
    '{1'h0, 16'hFFFF, 16'hFFFF, 16'h0000, 16'hFFFF},
    '{1'h0, 16'h0000, 16'h8000, 16'hFFFE, 16'h0000},
    '{1'h0, 16'hFFFF, 16'h0000, 16'h0010, 16'h800F}
  };
  dac_code_calibration dut (.*);
////////////////////////////////////////
  // 50 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // Tests need under 200 cycles; 1000 leaves margin
  initial
  begin
    #20000;
    error_cnt++;
    test_done();
  end
  // Inputs move just after the edge to stay clear of sampling
  task automatic cyc(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(string nm, logic [15:0] ex, logic [15:0] got);
    samples_checked++;
    if (got !== ex)
    begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, ex, got);
    end
  endtask
  // One strobe cycle, then room for the two-stage path
  task automatic pulse(logic [2:0] st);
    {gainWrite, offsetWrite, codeWrite} = st;
    cyc(1);
    {gainWrite, offsetWrite, codeWrite} = 3'h0;
    cyc(3);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Trims go four cycles ahead of the code, since a shared cycle sees the old gain
  initial
  begin
    {reset, clkEn, logicSupplyOk, output_supplyOk, spanSelect} = 5'h1F;
    {codeWrite, gainWrite, offsetWrite, clear_span_select, clearState} = 5'h00;
    {codeData, gainData, offsetData, clearCode} = 64'h0000_0000_0000_1234;
    resolution = RES_WIDE_E;
    alarm_action_config = ALARM_HOLD_E;
    cyc(12);
    reset = 1'h0;
    chk("gainTrim", 16'h8000, gainTrim);
    chk("dacCode", 16'h0000, dacCode);
    $display("reset test done");
    foreach (rows[i])
    begin
      {codeData, gainData, offsetData} = {rows[i].d, rows[i].g, rows[i].o};
      pulse(3'h6);
      chk("held", i ? rows[i-1].e : 16'h0000, dacCode);
      resolution = resolution_t'(rows[i].n);
      pulse(3'h1);
      chk("dacCode", rows[i].e, dacCode);
    end
    chk("writtenCode", 16'hFFFF, writtenCode);
    chk("offsetTrim", 16'h0010, offsetTrim);
    $display("table test done");
    for (int a = 0; a < 4; a++)
    begin
      alarm_action_config = alarm_action_t'(a);
      {logicSupplyOk, output_supplyOk} = a[0] ? 2'h1 : 2'h2;
      cyc(2);
      chk("alarm", 16'h0001, 16'(alarm));
      chk("alarmCode", alm[a], dacCode);
      chk("span", 16'(a != 2), 16'(span));
      {logicSupplyOk, output_supplyOk} = 2'h3;
      cyc(3);
    end
    $display("alarm test done");
    // Clear state by pin: clear code and clear span bit take over
    clearState = 1'h1;
    {spanSelect, clear_span_select} = 2'h1;
    cyc(2);
    chk("clearCode", 16'h1234, dacCode);
    chk("clearSpan", 16'h0001, 16'(span));
    clearState = 1'h0;
    cyc(2);
    chk("normalSpan", 16'h0000, 16'(span));
    chk("normalCode", 16'h800F, dacCode);
    $display("clear test done");
    // A low clock enable must swallow a code write
    clkEn = 1'h0;
    codeData = 16'h4000;
    pulse(3'h1);
    chk("frozen", 16'hFFFF, writtenCode);
    clkEn = 1'h1;
    pulse(3'h1);
    chk("dacCode", 16'h2010, dacCode);
    $display("enable test done");
    // Reset in mid-run, then a unity write and a narrow saturation
    reset = 1'h1;
    cyc(1);
    reset = 1'h0;
    chk("rstCode", 16'h0000, dacCode);
    chk("rstOffset", 16'h0000, offsetTrim);
    chk("rstGain", 16'h8000, gainTrim);
    chk("rstWritten", 16'h0000, writtenCode);
    codeData = 16'h8000;
    pulse(3'h1);
    chk("unity", 16'h8000, dacCode);
    offsetData = 16'h7FFF;
    codeData = 16'hFFFF;
    resolution = RES_NARROW_E;
    pulse(3'h2);
    pulse(3'h1);
    chk("narrowMax", 16'hFFFC, dacCode);
    $display("restart test done");
    test_done();
  end
endmodule
